/* dio_chan_ctrl.sv */
// Channel control: trip, reactivation, fallback, run/stop and panel indicators
// Contract
// - Channels form groups of 4, 8 or 16; each group goes to master or fast task.
// - Overload on an active output trips it, flashes its LED, lights module fault LED.
// - Reactivation per group of 8; inactive or healthy channels stay unchanged.
// - Reactivation re-enables only when no terminal fault is present.
// - Programmed reactivation on command, at least 10 s between two.
// - Automatic reactivation tries every 10 s until the fault clears.
// - Run/stop input acts on its rising edge only.
// - Stop from the input beats any run request from terminal or network.
// - Fallback behaviour applies on processor, rack or inter-rack cable fault.
// - Fallback mode drives each output to its group-of-8 fallback value; the code holds tripped channels off instead.
// - Maintain mode holds each output at its state just before the stop; the code holds tripped channels off instead.
// - Panel has 32 channel indicators, one per displayed channel.
// - Channel LED on for 1, off for 0, flashing when faulty.
// - Run LED on in normal operation; error steady internal, flashing exchange fault.
// - I/O LED steady on external fault, flashing on terminal block fault.
// - Pushbutton toggles upper-half view: channels 0-31 or 32-63.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module dio_chan_ctrl
  import dio_pkg::*;
#(
  parameter int unsigned REACT_CYC = REACT_CYC_DEF,
  parameter int unsigned FLASH_CYC = FLASH_CYC_DEF,
  parameter int unsigned DEB_CYC   = DEB_CYC_DEF
) (
  // Clock and reset
  input  logic            mclk,
  input  logic            srst,
  // Register port
  input  dio_req_t        req,
  output logic [31:0]     rdata,
  output logic            irq,
  // Rack side
  input  logic            run_req,
  input  dio_stop_t       stop_src,
  input  logic            int_fault,
  input  logic            exch_fault,
  output logic            plc_run,
  output logic [NCH-1:0]  chan_task,
  // Field pins
  input  logic [NCH-1:0]  ovl_pin,
  input  logic            rs_pin,
  input  logic            btn_pin,
  input  logic            term_fault_pin,
  input  logic            sup_fault_pin,
  output logic [NCH-1:0]  out_pin,
  // Panel
  output logic [NLED-1:0] chan_led,
  output logic            run_led,
  output logic            err_led,
  output logic            io_led,
  output logic            upper_led
);

  dio_st_t          q;
  dio_st_t          d;
  logic             stopped;
  logic             fault_stop;
  logic             tick;
  logic             rs_edge;
  logic             prog_go;
  logic [NG8-1:0]   prog_grp;
  logic [NCH-1:0]   rmask;
  logic [NCH-1:0]   new_trip;
  logic [NCH-1:0]   view_st;
  logic [NCH-1:0]   view_flt;
  logic [NEV-1:0]   ev;
  logic [NEV-1:0]   clr;
  logic             wr_hit;

  always_comb begin
    d        = q;
    ev       = '0;
    clr      = '0;
    tick     = 1'b0;
    prog_go  = 1'b0;
    prog_grp = '0;
    rmask    = '0;
    new_trip = '0;
    view_st  = '0;
    view_flt = '0;
    wr_hit   = 1'b0;
    d.rdata  = '0;

    // Two-stage synchronisers, first stage read only by the second
    d.ovl_s1 = ovl_pin;
    d.ovl_s2 = q.ovl_s1;
    d.pin_s1 = {sup_fault_pin, term_fault_pin, btn_pin, rs_pin};
    d.pin_s2 = q.pin_s1;

    // Common flash timebase for every flashing indicator
    if (q.flash_cnt == '0) begin
      d.flash_cnt = CW'(FLASH_CYC - 1);
      d.flash     = ~q.flash;
    end else begin
      d.flash_cnt = q.flash_cnt - 1'b1;
    end

    // Free-running automatic reactivation period
    if (q.period == '0) begin
      d.period = CW'(REACT_CYC - 1);
      tick     = 1'b1;
    end else begin
      d.period = q.period - 1'b1;
    end

    if (q.guard != '0) begin
      d.guard = q.guard - 1'b1;
    end

    // Programmed command is ignored while the guard runs
    if (req.wr && req.addr == A_RCMD) begin
      prog_grp = req.wdata[NG8-1:0] & ~q.react_auto;
      if (q.guard == '0 && prog_grp != '0 && !q.pin_s2[PIN_TERM]) begin
        prog_go = 1'b1;
        d.guard = CW'(REACT_CYC - 1);
      end
    end

    // Only tripped channels in the chosen groups are touched
    if (!q.pin_s2[PIN_TERM]) begin
      rmask = grp8_mask((prog_go ? prog_grp : '0)
                        | (tick ? q.react_auto : '0)) & q.trip;
    end
    if (rmask != '0) begin
      ev[EV_REACT] = 1'b1;
    end

    // A fresh overload wins over a reactivation in the same cycle
    new_trip = q.out & q.ovl_s2 & ~q.trip;
    d.trip   = (q.trip & ~rmask) | (q.out & q.ovl_s2);
    if (new_trip != '0) begin
      ev[EV_TRIP] = 1'b1;
    end

    // Run/stop: stop edge applied after run so it has priority
    d.rs_prev = q.pin_s2[PIN_RS];
    rs_edge   = q.ctrl[CTRL_RSEN] && q.pin_s2[PIN_RS] && !q.rs_prev;
    if (run_req) begin
      d.run = 1'b1;
    end
    if (rs_edge) begin
      d.run         = 1'b0;
      ev[EV_RSTOP]  = 1'b1;
    end

    fault_stop  = stop_src.proc | stop_src.rack | stop_src.cable;
    stopped     = !q.run || fault_stop;
    d.stop_prev = stopped;
    if (stopped && !q.stop_prev) begin
      ev[EV_STOP] = 1'b1;
    end

    // Protection keeps a tripped channel off even in fallback
    if (stopped) begin
      if (q.ctrl[CTRL_MAINT]) begin
        d.out = q.hold & ~q.trip;
      end else begin
        d.out = grp8_mask(q.fb_val) & ~q.trip;
      end
    end else begin
      d.out  = q.cmd & ~q.trip;
      d.hold = q.out;
    end

    d.term_prev = q.pin_s2[PIN_TERM];
    if (q.pin_s2[PIN_TERM] && !q.term_prev) begin
      ev[EV_TERM] = 1'b1;
    end

    // Debounce: level must hold DEB_CYC cycles before it counts
    if (q.pin_s2[PIN_BTN] != q.btn_stb) begin
      if (q.deb_cnt == CW'(DEB_CYC - 1)) begin
        d.deb_cnt = '0;
        d.btn_stb = q.pin_s2[PIN_BTN];
        if (q.pin_s2[PIN_BTN]) begin
          d.upper = ~q.upper;
        end
      end else begin
        d.deb_cnt = q.deb_cnt + 1'b1;
      end
    end else begin
      d.deb_cnt = '0;
    end

    // Channel indicators for the selected half
    view_st  = q.upper ? (q.out >> NLED) : q.out;
    view_flt = q.upper ? (q.trip >> NLED) : q.trip;
    for (int i = 0; i < NLED; i++) begin
      d.chan_led[i] = view_flt[i] ? q.flash : view_st[i];
    end

    d.stat_led[0] = q.run && !int_fault && !exch_fault;
    d.stat_led[1] = int_fault || (exch_fault && q.flash);
    // Steady external fault outranks the flashing terminal fault
    d.stat_led[2] = q.pin_s2[PIN_SUP] || (q.trip != '0)
                    || (q.pin_s2[PIN_TERM] && q.flash);
    d.stat_led[3] = q.upper;

    // Register writes
    if (req.wr) begin
      wr_hit = 1'b1;
      case (req.addr)
        A_CTRL:   d.ctrl       = req.wdata[1:0];
        A_TASK:   d.task_map   = req.wdata[NGRP-1:0];
        A_OUTLO:  d.cmd[31:0]  = req.wdata;
        A_OUTHI:  d.cmd[63:32] = req.wdata;
        A_FBVAL:  d.fb_val     = req.wdata[NG8-1:0];
        A_RAUTO:  d.react_auto = req.wdata[NG8-1:0];
        A_IRQST:  clr          = req.wdata[NEV-1:0];
        A_IRQMSK: d.irq_mask   = req.wdata[NEV-1:0];
        default:  wr_hit       = 1'b0;
      endcase
    end
    // Set beats clear
    d.irq_st = (q.irq_st & ~clr) | ev;

    // Register reads, unmapped addresses read zero
    if (req.rd) begin
      case (req.addr)
        A_CTRL:   d.rdata = {30'h0, q.ctrl};
        A_TASK:   d.rdata = 32'(q.task_map);
        A_OUTLO:  d.rdata = q.cmd[31:0];
        A_OUTHI:  d.rdata = q.cmd[63:32];
        A_FBVAL:  d.rdata = 32'(q.fb_val);
        A_RAUTO:  d.rdata = 32'(q.react_auto);
        A_TRIPLO: d.rdata = q.trip[31:0];
        A_TRIPHI: d.rdata = q.trip[63:32];
        A_STATE:  d.rdata = {27'h0, q.pin_s2[PIN_TERM], q.upper, (q.guard != '0),
                             stopped, q.run};
        A_IRQST:  d.rdata = 32'(q.irq_st);
        A_IRQMSK: d.rdata = 32'(q.irq_mask);
        default:  d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // Task bit per channel from its group
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      chan_task[i] = q.task_map[i / GRP_SZ];
    end
  end

  assign rdata     = q.rdata;
  assign irq       = |(q.irq_st & q.irq_mask);
  assign plc_run   = q.run;
  assign out_pin   = q.out;
  assign chan_led  = q.chan_led;
  assign run_led   = q.stat_led[0];
  assign err_led   = q.stat_led[1];
  assign io_led    = q.stat_led[2];
  assign upper_led = q.stat_led[3];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  trip_set_a: assert property ((q.out & q.ovl_s2) != '0 |=>
      (q.trip & $past(q.out & q.ovl_s2)) == $past(q.out & q.ovl_s2))
    else $error("Overloaded active output not tripped");

  trip_off_a: assert property (q.trip != '0 |=> (q.out & $past(q.trip)) == '0)
    else $error("Tripped output still driven");

  term_block_a: assert property (q.pin_s2[PIN_TERM] |=>
      (q.trip & $past(q.trip)) == $past(q.trip))
    else $error("Trip cleared during terminal fault");

  guard_idle_a: assert property (prog_go |-> q.guard == '0)
    else $error("Reactivation inside guard time");

  guard_load_a: assert property (prog_go |=> q.guard == CW'(REACT_CYC - 1))
    else $error("Guard not loaded after reactivation");

  stop_edge_a: assert property (rs_edge |=> !q.run [*2])
    else $error("Run survived stop edge");

  fallback_a: assert property (stopped && !q.ctrl[CTRL_MAINT] |=>
      q.out == $past(grp8_mask(q.fb_val) & ~q.trip))
    else $error("Fallback value not applied");

  maintain_a: assert property (stopped && q.ctrl[CTRL_MAINT] |=>
      q.out == $past(q.hold & ~q.trip))
    else $error("Maintained state lost");

  led_flash_a: assert property (!q.upper && q.trip[3] |=>
      q.chan_led[3] == $past(q.flash))
    else $error("Faulty channel LED not flashing");

  task_write_a: assert property (req.wr && req.addr == A_TASK |=>
      q.task_map == $past(req.wdata[NGRP-1:0]))
    else $error("Task map write lost");

  trip_led_a: assert property (q.trip != '0 |=> io_led)
    else $error("Module fault LED dark with a trip");

  trip_event_a: assert property (new_trip != '0 |=> q.irq_st[EV_TRIP])
    else $error("Trip event not recorded");

  react_only_a: assert property (rmask != '0 |=>
      (q.trip & $past(rmask & ~(q.out & q.ovl_s2))) == '0)
    else $error("Reactivated channel still tripped");

  term_nogo_a: assert property (q.pin_s2[PIN_TERM] |-> rmask == '0 && !prog_go)
    else $error("Reactivation during terminal fault");

  guard_count_a: assert property (q.guard != '0 |=>
      q.guard == $past(q.guard) - 1'b1)
    else $error("Guard time not counting down");

  guard_block_a: assert property (q.guard != '0 |->
      (rmask & ~grp8_mask(q.react_auto)) == '0)
    else $error("Programmed reactivation inside guard time");

  auto_clear_a: assert property (tick && !q.pin_s2[PIN_TERM] |=>
      (q.trip & $past(grp8_mask(q.react_auto) & q.trip & ~(q.out & q.ovl_s2))) == '0)
    else $error("Automatic reactivation skipped");

  period_count_a: assert property (q.period != '0 |=>
      q.period == $past(q.period) - 1'b1)
    else $error("Reactivation period not counting");

  rs_level_a: assert property (q.pin_s2[PIN_RS] && q.rs_prev && run_req |=> q.run)
    else $error("Run/stop level acted as a stop");

  stop_event_a: assert property (stopped && !q.stop_prev |=> q.irq_st[EV_STOP])
    else $error("Stop entry not recorded");

  fault_out_a: assert property (stop_src != '0 |=>
      (q.out & ~$past(grp8_mask(q.fb_val) | q.hold)) == '0)
    else $error("Output outside its stop state");

  run_out_a: assert property (!stopped |=> q.out == $past(q.cmd & ~q.trip))
    else $error("Running output differs from command");

  hold_track_a: assert property (!stopped |=> q.hold == $past(q.out))
    else $error("Held state not tracking the outputs");

  led_on_a: assert property (!q.upper && !q.trip[0] |=>
      q.chan_led[0] == $past(q.out[0]))
    else $error("Channel LED not showing its state");

  led_upper_a: assert property (q.upper && !q.trip[NLED] |=>
      q.chan_led[0] == $past(q.out[NLED]))
    else $error("Upper half not shown");

  run_led_a: assert property (1'b1 |=>
      run_led == $past(q.run && !int_fault && !exch_fault))
    else $error("Run LED wrong");

  err_steady_a: assert property (int_fault |=> err_led)
    else $error("Error LED not steady on internal fault");

  io_supply_a: assert property (q.pin_s2[PIN_SUP] |=> io_led)
    else $error("Fault LED not steady on supply loss");

  io_term_a: assert property (q.pin_s2[PIN_TERM] && !q.pin_s2[PIN_SUP]
      && q.trip == '0 |=> io_led == $past(q.flash))
    else $error("Fault LED not flashing on terminal fault");

  upper_once_a: assert property ($changed(q.upper) |->
      $past(q.deb_cnt) == CW'(DEB_CYC - 1) && $past(q.pin_s2[PIN_BTN]))
    else $error("Display view toggled without a settled press");

  flash_rate_a: assert property ($changed(q.flash) |-> $past(q.flash_cnt) == '0)
    else $error("Flash timebase off rate");

endmodule : dio_chan_ctrl

/* dio_pkg.sv */
// Package for the discrete I/O channel control block
package dio_pkg;

  localparam int NCH    = 64;          // Channels on the module
  localparam int GRP_SZ = 4;           // Task group size: 4, 8 or 16 by module type
  localparam int NGRP   = NCH / GRP_SZ;
  localparam int NG8    = NCH / 8;     // Groups of 8 for reactivation and fallback
  localparam int NLED   = 32;          // Channel indicators on the panel
  localparam int CW     = 30;          // Width of the long timers
  localparam int NEV    = 5;

  localparam longint CLK_HZ   = 100_000_000;
  localparam longint REACT_S  = 10;    // Reactivation guard and auto period, s
  localparam longint FLASH_MS = 250;   // Half period of every flashing indicator, ms
  localparam longint DEB_MS   = 10;    // Pushbutton settle time, ms

  localparam int unsigned REACT_CYC_DEF = 32'(REACT_S * CLK_HZ);
  localparam int unsigned FLASH_CYC_DEF = 32'(FLASH_MS * CLK_HZ / 1000);
  localparam int unsigned DEB_CYC_DEF   = 32'((DEB_MS * CLK_HZ + 999) / 1000);

  // Register byte addresses
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_TASK   = 8'h04;
  localparam logic [7:0] A_OUTLO  = 8'h08;
  localparam logic [7:0] A_OUTHI  = 8'h0C;
  localparam logic [7:0] A_FBVAL  = 8'h10;
  localparam logic [7:0] A_RAUTO  = 8'h14;
  localparam logic [7:0] A_RCMD   = 8'h18;
  localparam logic [7:0] A_TRIPLO = 8'h1C;
  localparam logic [7:0] A_TRIPHI = 8'h20;
  localparam logic [7:0] A_STATE  = 8'h24;
  localparam logic [7:0] A_IRQST  = 8'h28;
  localparam logic [7:0] A_IRQMSK = 8'h2C;

  // Field positions
  localparam int CTRL_MAINT = 0;
  localparam int CTRL_RSEN  = 1;
  localparam int EV_TRIP    = 0;
  localparam int EV_RSTOP   = 1;
  localparam int EV_STOP    = 2;
  localparam int EV_REACT   = 3;
  localparam int EV_TERM    = 4;
  localparam int PIN_RS     = 0;
  localparam int PIN_BTN    = 1;
  localparam int PIN_TERM   = 2;
  localparam int PIN_SUP    = 3;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dio_req_t;

  typedef struct packed {
    logic proc;
    logic rack;
    logic cable;
  } dio_stop_t;

  typedef struct packed {
    logic [NCH-1:0]  ovl_s1;
    logic [NCH-1:0]  ovl_s2;
    logic [NCH-1:0]  trip;
    logic [NCH-1:0]  hold;
    logic [NCH-1:0]  cmd;
    logic [NCH-1:0]  out;
    logic [3:0]      pin_s1;
    logic [3:0]      pin_s2;
    logic            rs_prev;
    logic            term_prev;
    logic            stop_prev;
    logic            btn_stb;
    logic            upper;
    logic            run;
    logic            flash;
    logic [CW-1:0]   guard;
    logic [CW-1:0]   period;
    logic [CW-1:0]   flash_cnt;
    logic [CW-1:0]   deb_cnt;
    logic [1:0]      ctrl;
    logic [NGRP-1:0] task_map;
    logic [NG8-1:0]  fb_val;
    logic [NG8-1:0]  react_auto;
    logic [NEV-1:0]  irq_st;
    logic [NEV-1:0]  irq_mask;
    logic [NLED-1:0] chan_led;
    logic [3:0]      stat_led;
    logic [31:0]     rdata;
  } dio_st_t;

  // Reset counts as already stopped, so release raises no stop event
  localparam dio_st_t ST_RST = '{stop_prev: 1'b1, default: '0};

  // Spread one bit per group of 8 over its channels
  function automatic logic [NCH-1:0] grp8_mask(input logic [NG8-1:0] g);
    logic [NCH-1:0] m;
    m = '0;
    for (int i = 0; i < NCH; i++) begin
      m[i] = g[i / 8];
    end
    return m;
  endfunction : grp8_mask

endpackage : dio_pkg

/* dio_rack_model.sv */
// Rack processor model: run requests, stop causes and module faults
`timescale 1ns/10ps
module dio_rack_model
  import dio_pkg::*;
(
  // Clock
  input  logic      mclk,
  // Toward the module
  output logic      run_req,
  output dio_stop_t stop_src,
  output logic      int_fault,
  output logic      exch_fault
);
  initial begin
    run_req    = 1'b0;
    stop_src   = '0;
    int_fault  = 1'b0;
    exch_fault = 1'b0;
  end
  // One-cycle pulse; never beside an input stop edge, so the run is never masked
  task automatic run;
    @(posedge mclk);
    run_req <= 1'b1;
    @(posedge mclk);
    run_req <= 1'b0;
  endtask : run
  task automatic set_stop(input dio_stop_t s);
    @(posedge mclk);
    stop_src <= s;
  endtask : set_stop
  task automatic set_faults(input logic i, input logic e);
    @(posedge mclk);
    int_fault  <= i;
    exch_fault <= e;
  endtask : set_faults
endmodule : dio_rack_model

/* tb_top.sv */
// Testbench for the discrete I/O channel control block
`timescale 1ns/10ps
module tb_top;
  import dio_pkg::*;
  logic            mclk = 1'b0;
  logic            srst = 1'b1;
  dio_req_t        req = '0;
  logic [31:0]     rdata;
  logic [NCH-1:0]  chan_task;
  logic [NCH-1:0]  out_pin;
  logic [NCH-1:0]  ovl_pin = '0;
  logic [NLED-1:0] chan_led;
  logic            irq, plc_run, run_req, int_fault, exch_fault;
  logic            run_led, err_led, io_led, upper_led;
  logic            rs_pin = 1'b0;
  logic            btn_pin = 1'b0;
  logic            term_pin = 1'b0;
  logic            sup_pin = 1'b0;
  dio_stop_t       stop_src;
  int              error_cnt = 0;
  int              cmp_count = 0;
  localparam logic [63:0] RUN_OUT = 64'h8000_0001_0000_00FF;

  always #5 mclk = ~mclk;

  // Short counts keep the run brief
  dio_chan_ctrl #(.REACT_CYC(50), .FLASH_CYC(4), .DEB_CYC(3)) dut (
    .mclk(mclk), .srst(srst), .req(req), .rdata(rdata), .irq(irq),
    .run_req(run_req), .stop_src(stop_src), .int_fault(int_fault),
    .exch_fault(exch_fault), .plc_run(plc_run), .chan_task(chan_task),
    .ovl_pin(ovl_pin), .rs_pin(rs_pin), .btn_pin(btn_pin),
    .term_fault_pin(term_pin), .sup_fault_pin(sup_pin), .out_pin(out_pin),
    .chan_led(chan_led), .run_led(run_led), .err_led(err_led),
    .io_led(io_led), .upper_led(upper_led)
  );

  dio_rack_model rack (
    .mclk(mclk), .run_req(run_req), .stop_src(stop_src),
    .int_fault(int_fault), .exch_fault(exch_fault)
  );

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req <= '0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    @(posedge mclk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req <= '0;
    #1 chk(64'(rdata & m), 64'(exp));
  endtask : rd

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  function automatic logic pick(input int w);
    case (w)
      0: return chan_led[3];
      1: return io_led;
      default: return err_led;
    endcase
  endfunction : pick

  // Twelve samples span more than one flash period of 8 cycles
  task automatic obs(input int w, input logic flash);
    int ones;
    ones = 0;
    repeat (12) begin
      @(posedge mclk);
      #1 ones += int'(pick(w));
    end
    chk(64'(flash ? (ones > 0 && ones < 12) : (ones == 12)), 64'h1);
  endtask : obs

  task automatic wrap_up;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    step(1);
    chk(out_pin, 64'h0);
    rd(A_CTRL, 32'h0);
    rd(8'h3C, 32'h0);
    wr(A_TASK, 32'h0000_0005);
    step(2);
    chk(chan_task, 64'h0F0F);
    rack.run();
    step(3);
    chk({plc_run, run_led}, 64'h3);
    wr(A_OUTLO, 32'h0000_00FF);
    wr(A_OUTHI, 32'h8000_0001);
    step(3);
    chk(out_pin, RUN_OUT);
    chk(chan_led, 64'hFF);
    // Overload on an active output
    wr(A_IRQMSK, 32'h1);
    @(posedge mclk) ovl_pin[3] <= 1'b1;
    step(6);
    @(posedge mclk) ovl_pin[3] <= 1'b0;
    #1 chk(out_pin, RUN_OUT & ~64'h8);
    rd(A_TRIPLO, 32'h8);
    chk(irq, 1'b1);
    obs(0, 1'b1);
    obs(1, 1'b0);
    wr(A_IRQMSK, 32'h0);
    step(1);
    chk(irq, 1'b0);
    wr(A_IRQST, 32'h1);
    rd(A_IRQST, 32'h0, 32'h1);
    wr(A_IRQMSK, 32'h1);
    step(1);
    chk(irq, 1'b0);
    // Terminal fault blocks reactivation
    @(posedge mclk) term_pin <= 1'b1;
    step(4);
    wr(A_RCMD, 32'h1);
    rd(A_TRIPLO, 32'h8);
    @(posedge mclk) term_pin <= 1'b0;
    step(4);
    wr(A_RCMD, 32'h1);
    rd(A_TRIPLO, 32'h0);
    chk(out_pin, RUN_OUT);
    // Second command inside the guard time is refused
    @(posedge mclk) ovl_pin[3] <= 1'b1;
    step(6);
    @(posedge mclk) ovl_pin[3] <= 1'b0;
    step(3);
    wr(A_RCMD, 32'h1);
    rd(A_TRIPLO, 32'h8);
    step(50);
    wr(A_RCMD, 32'h1);
    rd(A_TRIPLO, 32'h0);
    @(posedge mclk) term_pin <= 1'b1;
    step(4);
    obs(1, 1'b1);
    @(posedge mclk) term_pin <= 1'b0;
    step(4);
    // Automatic retry with no command
    wr(A_RAUTO, 32'h1);
    @(posedge mclk) ovl_pin[3] <= 1'b1;
    step(6);
    @(posedge mclk) ovl_pin[3] <= 1'b0;
    step(60);
    rd(A_TRIPLO, 32'h0);
    chk(out_pin, RUN_OUT);
    wr(A_RAUTO, 32'h0);
    @(posedge mclk) sup_pin <= 1'b1;
    step(4);
    obs(1, 1'b0);
    @(posedge mclk) sup_pin <= 1'b0;
    step(4);
    chk(io_led, 1'b0);
    // Display select, then a one-cycle bounce
    @(posedge mclk) btn_pin <= 1'b1;
    step(10);
    @(posedge mclk) btn_pin <= 1'b0;
    step(8);
    chk({upper_led, chan_led}, {1'b1, 32'h8000_0001});
    @(posedge mclk) btn_pin <= 1'b1;
    @(posedge mclk) btn_pin <= 1'b0;
    step(8);
    chk(upper_led, 1'b1);
    rack.set_faults(1'b1, 1'b0);
    step(3);
    obs(2, 1'b0);
    rack.set_faults(1'b0, 1'b1);
    obs(2, 1'b1);
    rack.set_faults(1'b0, 1'b0);
    // Stop from the run/stop input, fallback values
    wr(A_FBVAL, 32'h2);
    wr(A_CTRL, 32'h2);
    @(posedge mclk) rs_pin <= 1'b1;
    step(5);
    chk(plc_run, 1'b0);
    chk(out_pin, 64'hFF00);
    rd(A_IRQST, 32'h0000_001F);
    rack.run();
    step(3);
    chk(plc_run, 1'b1);
    // Maintain mode on a processor fault
    wr(A_CTRL, 32'h3);
    rack.set_stop(3'b100);
    step(3);
    chk({plc_run, out_pin}, {1'b1, RUN_OUT});
    rd(A_STATE, 32'h0000_000B);
    wr(A_OUTLO, 32'h0);
    step(3);
    chk(out_pin, RUN_OUT);
    rack.set_stop(3'b000);
    wr(A_CTRL, 32'h2);
    rack.run();
    step(3);
    chk(out_pin, 64'h8000_0001_0000_0000);
    rack.set_stop(3'b001);
    step(3);
    chk({plc_run, out_pin}, {1'b1, 64'hFF00});
    rd(A_STATE, 32'h0000_0002, 32'h0000_0002);
    wrap_up();
  end
endmodule : tb_top
